// [rtl/tcm_defines.svh]
// register offsets, field codes and reset values of the timer channel
`ifndef TCM_DEFINES_SVH
`define TCM_DEFINES_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define TCM_A_MODE 8'h00
`define TCM_A_CMP 8'h04
`define TCM_A_OUT 8'h08
`define TCM_A_OE 8'h0C
`define TCM_A_CTRL 8'h10
`define TCM_A_CNT 8'h14
`define TCM_A_CAP 8'h18
`define TCM_A_STAT 8'h1C
`define TCM_A_MASK 8'h20

// ----------------------------------------
// field codes
// ----------------------------------------
`define TCM_MD_IV 3'h0
`define TCM_MD_CP 3'h2
`define TCM_MD_EV 3'h3
`define TCM_MD_OC 3'h4
`define TCM_MD_CO 3'h6
`define TCM_ST_SW 3'h0
`define TCM_ST_EDGE 3'h1
`define TCM_ST_BOTH 3'h2
`define TCM_ST_SLAVE 3'h4
`define TCM_CIS_FALL 2'h0
`define TCM_CIS_RISE 2'h1
`define TCM_CTRL_START 0
`define TCM_CTRL_STOP 1
`define TCM_EV_INT 0
`define TCM_EV_CAP 1

// ----------------------------------------
// reset values and answers
// ----------------------------------------
`define TCM_MODE_RST 16'h0000
`define TCM_CMP_RST 16'h0000
`define TCM_RESP_OK 2'h0
`define TCM_RESP_ERR 2'h2

`endif

// [rtl/tcm_pkg.sv]
// types shared by the timer channel
package tcm_pkg;
  typedef struct packed {
    logic [1:0] operation_clock_select;
    logic rsv0;
    logic count_clock_select;
    logic rsv1;
    logic [2:0] sts;
    logic [1:0] cis;
    logic [1:0] rsv2;
    logic [3:0] md;
  } tcm_mode_t;

  typedef struct packed {
    logic cap;
    logic intr;
  } tcm_ev_t;

  typedef enum logic {ST_IDLE, ST_RUN} tcm_state_t;
endpackage : tcm_pkg

// [rtl/tcm_channel.sv]
// one timer channel: triggers, modes, output bit, axi4-lite registers
//
// Decided for this implementation: the register addresses and register access over AXI4-Lite.
`timescale 1ns/1ps
`include "tcm_defines.svh"

module tcm_channel import tcm_pkg::*; #(
  parameter int CHANNEL_ID = 0
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [3:0] op_clk_en,
  input wire logic timer_input_pin,
  input wire logic master_irq,
  output logic timer_output,
  output logic chan_irq_pulse,
  output logic irq,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  if (CHANNEL_ID < 0 || CHANNEL_ID > 3) begin : g_bad_id
    $error("tcm_channel: CHANNEL_ID must be 0 to 3");
  end

  // ----------------------------------------
  // state
  // ----------------------------------------
  tcm_mode_t mode;
  tcm_state_t state;
  tcm_state_t next_state;
  tcm_ev_t stat;
  tcm_ev_t mask;
  tcm_ev_t ev;
  logic [15:0] cmp;
  logic [15:0] cnt;
  logic [15:0] cap;
  logic [15:0] next_cnt;
  logic [15:0] next_cap;
  logic oe;
  logic tog;
  logic ti_s1;
  logic ti_s2;
  logic ti_d;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;

  // ----------------------------------------
  // pin synchroniser and edges
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ti_s1 <= 1'b0;
      ti_s2 <= 1'b0;
      ti_d <= 1'b0;
    end else begin
      ti_s1 <= timer_input_pin;
      ti_s2 <= ti_s1;
      ti_d <= ti_s2;
    end
  end

  wire rise = ti_s2 & ~ti_d;
  wire fall = ~ti_s2 & ti_d;
  wire any_edge = rise | fall;
  wire edge_sel = (mode.cis == `TCM_CIS_FALL) ? fall :
                  (mode.cis == `TCM_CIS_RISE) ? rise : any_edge;

  // ----------------------------------------
  // register bus decode
  // ----------------------------------------
  wire aw_hs = s_axi_awvalid & s_axi_awready;
  wire w_hs = s_axi_wvalid & s_axi_wready;
  wire ar_hs = s_axi_arvalid & s_axi_arready;
  // both halves held, response not yet raised
  wire wr_fire = ~s_axi_awready & ~s_axi_wready & ~s_axi_bvalid;
  wire wr_mode = wr_fire & (wr_addr == `TCM_A_MODE);
  wire wr_cmp = wr_fire & (wr_addr == `TCM_A_CMP);
  wire wr_out = wr_fire & (wr_addr == `TCM_A_OUT) & wr_strb[0];
  wire wr_oe = wr_fire & (wr_addr == `TCM_A_OE) & wr_strb[0];
  wire wr_ctrl = wr_fire & (wr_addr == `TCM_A_CTRL) & wr_strb[0];
  wire wr_mask = wr_fire & (wr_addr == `TCM_A_MASK) & wr_strb[0];
  wire wr_ro = (wr_addr == `TCM_A_CNT) | (wr_addr == `TCM_A_CAP) |
               (wr_addr == `TCM_A_STAT);
  wire wr_ok = (wr_addr == `TCM_A_MODE) | (wr_addr == `TCM_A_CMP) |
               (wr_addr == `TCM_A_OUT) | (wr_addr == `TCM_A_OE) |
               (wr_addr == `TCM_A_CTRL) | (wr_addr == `TCM_A_MASK) | wr_ro;
  wire sw_start = wr_ctrl & wr_data[`TCM_CTRL_START];
  wire sw_stop = wr_ctrl & wr_data[`TCM_CTRL_STOP];
  wire rd_stat = ar_hs & (s_axi_araddr == `TCM_A_STAT);
  wire [15:0] wmask = {{8{wr_strb[1]}}, {8{wr_strb[0]}}};

  logic [31:0] rd_mux;
  logic rd_ok;
  always_comb begin
    rd_ok = 1'b1;
    case (s_axi_araddr)
      `TCM_A_MODE: rd_mux = {16'h0000, mode};
      `TCM_A_CMP: rd_mux = {16'h0000, cmp};
      `TCM_A_OUT: rd_mux = {31'h00000000, timer_output};
      `TCM_A_OE: rd_mux = {31'h00000000, oe};
      `TCM_A_CTRL: rd_mux = {31'h00000000, state == ST_RUN};
      `TCM_A_CNT: rd_mux = {16'h0000, cnt};
      `TCM_A_CAP: rd_mux = {16'h0000, cap};
      `TCM_A_STAT: rd_mux = {30'h00000000, stat};
      `TCM_A_MASK: rd_mux = {30'h00000000, mask};
      default: begin
        rd_mux = 32'h00000000;
        rd_ok = 1'b0;
      end
    endcase
  end

  // ----------------------------------------
  // trigger and count clock selection
  // ----------------------------------------
  logic trig;
  always_comb begin
    case (mode.sts)
      `TCM_ST_SW: trig = 1'b0;
      `TCM_ST_EDGE: trig = edge_sel;
      `TCM_ST_BOTH: trig = any_edge;
      `TCM_ST_SLAVE: trig = master_irq;
      default: trig = 1'b0;
    endcase
  end
  wire start = sw_start | trig;

  // third and fourth clocks fall back to the first off channels 1 and 3
  wire hi_ok = (CHANNEL_ID == 1) || (CHANNEL_ID == 3);
  wire op_tick = (mode.operation_clock_select == 2'h0) ? op_clk_en[0] :
                 (mode.operation_clock_select == 2'h2) ? op_clk_en[1] :
                 !hi_ok ? op_clk_en[0] :
                 (mode.operation_clock_select == 2'h1) ? op_clk_en[2] : op_clk_en[3];
  wire tick = mode.count_clock_select ? edge_sel : op_tick;
  wire [2:0] md3 = mode.md[3:1];
  wire md0 = mode.md[0];
  wire run = (state == ST_RUN);

  // ----------------------------------------
  // counting core
  // ----------------------------------------
  always_comb begin
    next_state = state;
    next_cnt = cnt;
    next_cap = cap;
    ev = '0;
    tog = 1'b0;
    if (sw_stop) begin
      next_state = ST_IDLE;
    end else begin
      case (md3)
        `TCM_MD_IV, `TCM_MD_EV: begin
          if (!run) begin
            if (start) begin
              next_cnt = cmp;
              next_state = ST_RUN;
              // event counter never flags its start
              ev.intr = (md3 == `TCM_MD_IV) & md0;
              tog = (md3 == `TCM_MD_IV) & md0;
            end
          end else if (tick) begin
            if (cnt == 16'h0000) begin
              next_cnt = cmp;
              ev.intr = 1'b1;
              tog = 1'b1;
            end else begin
              next_cnt = cnt - 16'h0001;
            end
          end
        end
        `TCM_MD_CP: begin
          if (!run) begin
            if (start) begin
              next_cnt = 16'h0000;
              next_state = ST_RUN;
              ev.intr = md0;
              tog = md0;
            end
          end else if (trig) begin
            next_cap = cnt;
            next_cnt = 16'h0000;
            ev.intr = 1'b1;
            ev.cap = 1'b1;
          end else if (tick) begin
            next_cnt = cnt + 16'h0001;
          end
        end
        `TCM_MD_OC: begin
          if (!run) begin
            if (start) begin
              next_cnt = cmp;
              next_state = ST_RUN;
            end
          end else if (start && md0) begin
            next_cnt = cmp;
            ev.intr = 1'b1;
          end else if (tick) begin
            if (cnt == 16'h0000) begin
              next_state = ST_IDLE;
              ev.intr = 1'b1;
              tog = 1'b1;
            end else begin
              next_cnt = cnt - 16'h0001;
            end
          end
        end
        `TCM_MD_CO: begin
          if (!run) begin
            if (start) begin
              next_cnt = 16'h0000;
              next_state = ST_RUN;
            end
          end else if (any_edge) begin
            // the closing edge captures; starts are not looked at here
            next_cap = cnt;
            next_state = ST_IDLE;
            ev.intr = 1'b1;
            ev.cap = 1'b1;
          end else if (tick) begin
            next_cnt = cnt + 16'h0001;
          end
        end
        default: next_state = ST_IDLE;
      endcase
    end
  end

  // output bit: timer owns it when enabled, software otherwise
  wire next_out = oe ? (timer_output ^ tog) :
                  wr_out ? wr_data[0] : timer_output;
  // set wins over the read clear
  wire [1:0] next_stat = (stat & ~{2{rd_stat}}) | ev;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= ST_IDLE;
      cnt <= 16'h0000;
      cap <= 16'h0000;
      timer_output <= 1'b0;
      chan_irq_pulse <= 1'b0;
      stat <= '0;
      irq <= 1'b0;
    end else begin
      state <= next_state;
      cnt <= next_cnt;
      cap <= next_cap;
      timer_output <= next_out;
      chan_irq_pulse <= ev.intr;
      stat <= next_stat;
      irq <= |(next_stat & mask);
    end
  end

  // ----------------------------------------
  // software registers
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      mode <= `TCM_MODE_RST;
      cmp <= `TCM_CMP_RST;
      oe <= 1'b0;
      mask <= '0;
    end else begin
      if (wr_mode) mode <= (mode & ~wmask) | (wr_data[15:0] & wmask);
      if (wr_cmp) cmp <= (cmp & ~wmask) | (wr_data[15:0] & wmask);
      if (wr_oe) oe <= wr_data[0];
      if (wr_mask) mask <= wr_data[1:0];
    end
  end

  // ----------------------------------------
  // axi4-lite handshakes, one write and one read at a time
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `TCM_RESP_OK;
      wr_addr <= 8'h00;
      wr_data <= 32'h00000000;
      wr_strb <= 4'h0;
    end else begin
      if (aw_hs) begin
        s_axi_awready <= 1'b0;
        wr_addr <= s_axi_awaddr;
      end
      if (w_hs) begin
        s_axi_wready <= 1'b0;
        wr_data <= s_axi_wdata;
        wr_strb <= s_axi_wstrb;
      end
      if (wr_fire) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? `TCM_RESP_OK : `TCM_RESP_ERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `TCM_RESP_OK;
    end else if (ar_hs) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_mux;
      s_axi_rresp <= rd_ok ? `TCM_RESP_OK : `TCM_RESP_ERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  wire iv_sel = (md3 == `TCM_MD_IV);
  wire up_md = (md3 == `TCM_MD_CP) | (md3 == `TCM_MD_CO);
  wire known_md = iv_sel | up_md | (md3 == `TCM_MD_EV) | (md3 == `TCM_MD_OC);

  a_sw_only: assert property (
    !run && mode.sts == `TCM_ST_SW && !sw_start |=> state == ST_IDLE)
    else $error("started without software trigger");
  a_edge_start: assert property (
    !run && known_md && mode.sts == `TCM_ST_EDGE && edge_sel && !sw_stop
    |=> run && cnt == ($past(up_md) ? 16'h0000 : $past(cmp)))
    else $error("valid edge did not start");
  a_both_edges: assert property (
    !run && known_md && mode.sts == `TCM_ST_BOTH && fall && !sw_stop |=> run)
    else $error("falling edge did not start");
  a_slave_start: assert property (
    !run && known_md && mode.sts == `TCM_ST_SLAVE && master_irq && !sw_stop |=> run)
    else $error("master interrupt did not start");
  a_interval_down: assert property (
    run && iv_sel && tick && cnt != 16'h0000 && !sw_stop
    |=> cnt == $past(cnt) - 16'h0001)
    else $error("interval counter not counting down");
  a_interval_reload: assert property (
    run && iv_sel && tick && cnt == 16'h0000 && !sw_stop
    |=> cnt == $past(cmp) && chan_irq_pulse)
    else $error("interval reload missing");
  a_capture_up: assert property (
    run && md3 == `TCM_MD_CP && tick && !trig && !sw_stop
    |=> cnt == $past(cnt) + 16'h0001)
    else $error("capture counter not counting up");
  a_co_quiet: assert property (
    !run && md3 == `TCM_MD_CO && start && !sw_stop && !wr_out
    |=> run && !chan_irq_pulse && $stable(timer_output))
    else $error("capture one-count start not quiet");
  a_start_irq: assert property (
    !run && iv_sel && md0 && start && oe && !sw_stop
    |=> chan_irq_pulse && timer_output != $past(timer_output))
    else $error("start interrupt or toggle missing");
  a_event_quiet: assert property (
    !run && md3 == `TCM_MD_EV && start |=> !chan_irq_pulse)
    else $error("event counter flagged its start");
  a_oc_ignore: assert property (
    run && md3 == `TCM_MD_OC && !md0 && start && cnt != 16'h0000 && !sw_stop
    |=> !chan_irq_pulse && cnt == ($past(tick) ? $past(cnt) - 16'h0001 : $past(cnt)))
    else $error("one-count accepted a running trigger");
  a_oc_retrig: assert property (
    run && md3 == `TCM_MD_OC && md0 && start && !sw_stop
    |=> cnt == $past(cmp) && chan_irq_pulse)
    else $error("one-count retrigger missing");
  a_out_fixed: assert property (
    !oe && !wr_out |=> $stable(timer_output))
    else $error("disabled output changed");
  a_out_locked: assert property (
    oe && !tog |=> $stable(timer_output))
    else $error("enabled output changed without timer");

  c_reload: cover property (run && iv_sel && tick && cnt == 16'h0000);
  c_capture: cover property (ev.cap && md3 == `TCM_MD_CP);
  c_oc_end: cover property (run && md3 == `TCM_MD_OC ##1 !run);
  c_retrig: cover property (run && md3 == `TCM_MD_OC && md0 && start);
endmodule : tcm_channel

// [test/tcm_far.sv]
// far-side model: timer input pin source and master channel interrupt
`timescale 1ns/1ps

module tcm_far (
  input wire logic clk,
  output logic timer_input_pin,
  output logic master_irq
);
  initial begin
    timer_input_pin = 1'b0;
    master_irq = 1'b0;
  end

  // ----------------------------------------
  // pin and master pulse
  // ----------------------------------------
  // level held past the two sync flops and the edge detector
  task automatic pin(input logic v);
    @(posedge clk);
    timer_input_pin <= v;
    repeat (6) @(posedge clk);
  endtask : pin

  // single-cycle pulse, as a master channel gives it
  task automatic fire;
    @(posedge clk);
    master_irq <= 1'b1;
    @(posedge clk);
    master_irq <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : fire
endmodule : tcm_far

// [test/tcm_tb.sv]
// self-checking bench of one timer channel
`timescale 1ns/1ps
`include "tcm_defines.svh"
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin failures++; \
  $display("Error %s expected %h seen %h", n, e, g); end end

module testbench import tcm_pkg::*;;
  logic clk = 1'b0;
  logic rst_b;
  logic [3:0] op_clk_en;
  logic [1:0] pc = 2'h0;
  logic timer_input_pin, master_irq, timer_output, chan_irq_pulse, irq;
  logic [7:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rv;
  logic [3:0] s_axi_wstrb;
  logic s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr, br;
  logic o;
  int failures, tests_run, np, gap, last, cyc, n0;
  logic [7:0] ra [9] = '{`TCM_A_MODE, `TCM_A_CMP, `TCM_A_OUT, `TCM_A_OE, `TCM_A_CTRL,
    `TCM_A_CNT, `TCM_A_CAP, `TCM_A_STAT, `TCM_A_MASK};

  tcm_channel #(.CHANNEL_ID(0)) dut (.clk, .rst_b, .op_clk_en, .timer_input_pin,
    .master_irq, .timer_output, .chan_irq_pulse, .irq, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);
  tcm_far far (.clk, .timer_input_pin, .master_irq);

  initial begin
    forever #5 clk = ~clk;
  end

  // ----------------------------------------
  // prescaler enables and pulse monitor
  // ----------------------------------------
  // en0 every cycle, en1 every second, en2/en3 every fourth
  always @(posedge clk) begin
    cyc <= cyc + 1;
    pc <= pc + 2'h1;
    op_clk_en <= {pc == 2'h3, pc == 2'h3, pc[0], 1'b1};
    if (chan_irq_pulse === 1'b1) begin
      np <= np + 1;
      gap <= cyc - last;
      last <= cyc;
    end
  end

  // ----------------------------------------
  // bus tasks
  // ----------------------------------------
  task automatic summarize;
    $display("comparisons %0d failures %0d", tests_run, failures);
    if (failures == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask : summarize

  task automatic tk(input int n);
    repeat (n) @(posedge clk);
  endtask : tk

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s = 4'hF);
    int i;
    @(posedge clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (s_axi_awready === 1'b1) s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid === 1'b1) break;
    end
    s_axi_bready <= 1'b0;
    br = s_axi_bresp;
    if (i == 50) begin
      failures++;
      summarize();
    end
  endtask : wr

  task automatic rd(input logic [7:0] a);
    int i;
    @(posedge clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (s_axi_arready === 1'b1) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid === 1'b1) break;
    end
    s_axi_rready <= 1'b0;
    rv = s_axi_rdata;
    rr = s_axi_rresp;
    if (i == 50) begin
      failures++;
      summarize();
    end
  endtask : rd

  function automatic logic [31:0] mw(input logic [1:0] k, input logic c,
    input logic [2:0] s, input logic [1:0] e, input logic [3:0] m);
    tcm_mode_t t;
    t = '0;
    t.operation_clock_select = k;
    t.count_clock_select = c;
    t.sts = s;
    t.cis = e;
    t.md = m;
    return {16'h0, t};
  endfunction : mw

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_rst;
    foreach (ra[i]) begin
      rd(ra[i]);
      `CHK("reset value", 32'h0, rv)
    end
    rd(8'h40);
    `CHK("unmapped read", `TCM_RESP_ERR, rr)
    wr(8'h40, 32'h1);
    `CHK("unmapped write", `TCM_RESP_ERR, br)
    wr(`TCM_A_CMP, 32'h0000ABCD, 4'h2);
    rd(`TCM_A_CMP);
    `CHK("byte strobe", 32'h0000AB00, rv)
    wr(`TCM_A_OE, 32'h1, 4'h2);
    rd(`TCM_A_OE);
    `CHK("strobe off", 32'h0, rv)
    `CHK("reset pin", 1'b0, timer_output)
  endtask : t_rst

  task automatic t_intv;
    wr(`TCM_A_CMP, 32'h3);
    wr(`TCM_A_OE, 32'h1);
    for (int k = 0; k < 4; k++) begin
      wr(`TCM_A_MODE, mw(k[1:0], 1'b0, `TCM_ST_SW, 2'h0, 4'h1));
      n0 = np;
      o = timer_output;
      wr(`TCM_A_CTRL, 32'h1);
      tk(1);
      `CHK("start pulse", n0 + 1, np)
      `CHK("start toggle", ~o, timer_output)
      rd(`TCM_A_CNT);
      `CHK("counting down", 1'b1, rv < 32'h3)
      tk(20);
      `CHK("period", (k == 2) ? 8 : 4, gap)
      wr(`TCM_A_CTRL, 32'h2);
    end
    wr(`TCM_A_MODE, mw(2'h0, 1'b0, `TCM_ST_SW, 2'h0, 4'h0));
    n0 = np;
    wr(`TCM_A_CTRL, 32'h1);
    tk(2);
    `CHK("quiet start", n0, np)
    wr(`TCM_A_CTRL, 32'h2);
  endtask : t_intv

  task automatic t_irq;
    wr(`TCM_A_MASK, 32'h1);
    rd(`TCM_A_STAT);
    wr(`TCM_A_CTRL, 32'h1);
    tk(10);
    wr(`TCM_A_CTRL, 32'h2);
    `CHK("irq raised", 1'b1, irq)
    rd(`TCM_A_STAT);
    `CHK("status", 32'h1, rv & 32'h1)
    tk(2);
    `CHK("irq cleared", 1'b0, irq)
    wr(`TCM_A_MASK, 32'h0);
    wr(`TCM_A_CTRL, 32'h1);
    tk(10);
    wr(`TCM_A_CTRL, 32'h2);
    `CHK("irq masked", 1'b0, irq)
    rd(`TCM_A_STAT);
    `CHK("status masked", 32'h1, rv & 32'h1)
  endtask : t_irq

  task automatic t_out;
    wr(`TCM_A_OE, 32'h0);
    wr(`TCM_A_OUT, 32'h1);
    tk(1);
    `CHK("out written", 1'b1, timer_output)
    rd(`TCM_A_OUT);
    `CHK("out read", 32'h1, rv)
    wr(`TCM_A_MODE, mw(2'h0, 1'b0, `TCM_ST_SW, 2'h0, 4'h1));
    wr(`TCM_A_CTRL, 32'h1);
    tk(12);
    wr(`TCM_A_CTRL, 32'h2);
    `CHK("out fixed", 1'b1, timer_output)
    wr(`TCM_A_OE, 32'h1);
    wr(`TCM_A_OUT, 32'h0);
    tk(1);
    `CHK("write ignored", 1'b1, timer_output)
  endtask : t_out

  task automatic t_cap;
    logic [31:0] c1;
    wr(`TCM_A_MODE, mw(2'h0, 1'b0, `TCM_ST_EDGE, `TCM_CIS_RISE, 4'h4));
    rd(`TCM_A_STAT);
    far.pin(1'b1);
    rd(`TCM_A_CTRL);
    `CHK("edge start", 32'h1, rv)
    rd(`TCM_A_CNT);
    c1 = rv;
    far.pin(1'b0);
    rd(`TCM_A_CNT);
    `CHK("counting up", 1'b1, rv > c1)
    rd(`TCM_A_STAT);
    `CHK("fall ignored", 32'h0, rv & 32'h2)
    far.pin(1'b1);
    rd(`TCM_A_STAT);
    `CHK("rise captures", 32'h2, rv & 32'h2)
    rd(`TCM_A_CAP);
    `CHK("captured", 1'b1, rv > c1)
    wr(`TCM_A_CTRL, 32'h2);
    wr(`TCM_A_MODE, mw(2'h0, 1'b0, `TCM_ST_BOTH, `TCM_CIS_RISE, 4'h4));
    rd(`TCM_A_STAT);
    far.pin(1'b0);
    rd(`TCM_A_CTRL);
    `CHK("fall starts", 32'h1, rv)
    far.pin(1'b1);
    rd(`TCM_A_STAT);
    `CHK("both capture", 32'h2, rv & 32'h2)
    wr(`TCM_A_CTRL, 32'h2);
    wr(`TCM_A_MODE, mw(2'h0, 1'b0, `TCM_ST_SW, `TCM_CIS_RISE, 4'h4));
    far.pin(1'b0);
    far.fire();
    rd(`TCM_A_CTRL);
    `CHK("software only", 32'h0, rv)
    wr(`TCM_A_MODE, mw(2'h0, 1'b0, `TCM_ST_EDGE, `TCM_CIS_FALL, 4'h4));
    far.pin(1'b1);
    rd(`TCM_A_CTRL);
    `CHK("rise ignored", 32'h0, rv)
    far.pin(1'b0);
    rd(`TCM_A_CTRL);
    `CHK("fall starts edge", 32'h1, rv)
    wr(`TCM_A_CTRL, 32'h2);
  endtask : t_cap

  task automatic t_slave;
    wr(`TCM_A_CMP, 32'h5);
    wr(`TCM_A_MODE, mw(2'h0, 1'b0, `TCM_ST_SLAVE, 2'h0, 4'h8));
    n0 = np;
    far.fire();
    rd(`TCM_A_CTRL);
    `CHK("master start", 32'h1, rv)
    `CHK("no start pulse", n0, np)
    tk(12);
    `CHK("one count end", n0 + 1, np)
    rd(`TCM_A_CTRL);
    `CHK("one count idle", 32'h0, rv)
  endtask : t_slave

  task automatic t_one;
    wr(`TCM_A_CMP, 32'd40);
    for (int b = 0; b < 2; b++) begin
      wr(`TCM_A_MODE, mw(2'h0, 1'b0, `TCM_ST_SW, 2'h0, {3'h4, b[0]}));
      wr(`TCM_A_CTRL, 32'h1);
      tk(5);
      n0 = np;
      wr(`TCM_A_CTRL, 32'h1);
      tk(2);
      `CHK("retrigger pulse", n0 + b, np)
      tk(33);
      rd(`TCM_A_CTRL);
      `CHK("restarted", b, rv)
      wr(`TCM_A_CTRL, 32'h2);
    end
  endtask : t_one

  task automatic t_co;
    wr(`TCM_A_MODE, mw(2'h0, 1'b0, `TCM_ST_EDGE, `TCM_CIS_RISE, 4'hC));
    rd(`TCM_A_STAT);
    n0 = np;
    o = timer_output;
    far.pin(1'b1);
    rd(`TCM_A_CTRL);
    `CHK("co start", 32'h1, rv)
    wr(`TCM_A_CTRL, 32'h1);
    tk(2);
    `CHK("co quiet", n0, np)
    `CHK("co output", o, timer_output)
    far.pin(1'b0);
    `CHK("co end pulse", n0 + 1, np)
    rd(`TCM_A_STAT);
    `CHK("co capture", 32'h2, rv & 32'h2)
  endtask : t_co

  task automatic t_ev;
    wr(`TCM_A_CMP, 32'h2);
    wr(`TCM_A_MODE, mw(2'h0, 1'b1, `TCM_ST_SW, `TCM_CIS_RISE, 4'h6));
    n0 = np;
    o = timer_output;
    wr(`TCM_A_CTRL, 32'h1);
    tk(2);
    `CHK("ev quiet", n0, np)
    `CHK("ev output", o, timer_output)
    for (int i = 0; i < 3; i++) begin
      far.pin(1'b1);
      far.pin(1'b0);
      `CHK("pin ticks", n0 + (i == 2), np)
    end
    wr(`TCM_A_CTRL, 32'h2);
  endtask : t_ev

  initial begin
    rst_b <= 1'b0;
    s_axi_awaddr <= 8'h00;
    s_axi_araddr <= 8'h00;
    s_axi_wdata <= 32'h00000000;
    s_axi_wstrb <= 4'hF;
    s_axi_awvalid <= 1'b0;
    s_axi_wvalid <= 1'b0;
    s_axi_bready <= 1'b0;
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b0;
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    t_rst();
    t_intv();
    t_irq();
    t_out();
    t_cap();
    t_slave();
    t_one();
    t_co();
    t_ev();
    summarize();
  end
endmodule : testbench
